// [logic/dccr_regs.sv]
/*
  dccr_regs: control, mode and input select registers of two voltage comparators, their
  edge flags, interrupt requests and synchronous outputs toward the port crossbar.
  Assumes the core's special-function register bus: one-cycle read and write strobes with an
  8-bit address, read data returned from a flop one cycle after the read strobe.
  The analog comparators, the port crossbar and the interrupt controller live outside.
*/
`timescale 1ns/10ps
`default_nettype none

module dccr_regs (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // special-function register bus
  input  wire logic [7:0]            i_sfr_addr,
  input  wire logic                  i_sfr_wr,
  input  wire logic [7:0]            i_sfr_wdata,
  input  wire logic                  i_sfr_rd,
  output logic      [7:0]            o_sfr_rdata,
  // analog comparators
  input  wire logic [1:0]            i_cmp_raw,
  output dccr_pkg::dccr_cfg_t [1:0]  o_cmp_cfg,
  output logic      [1:0][15:0]      o_cmp_pos_pins,
  output logic      [1:0][15:0]      o_cmp_neg_pins,
  // to crossbar and interrupt controller
  output logic      [1:0]            o_cmp_pin_out,
  output logic      [1:0]            o_cmp_irq
);
  import dccr_pkg::*;

  // one-hot register hit: 0 ctl0, 1 ctl1, 2 mode0, 3 mode1, 4 sel0, 5 sel1
  function automatic logic [5:0] reg_hit(input logic [7:0] addr);
    case (addr)
      ADDR_CMP0_CONTROL: reg_hit = 6'h01;
      ADDR_CMP1_CONTROL: reg_hit = 6'h02;
      ADDR_CMP0_MODE:    reg_hit = 6'h04;
      ADDR_CMP1_MODE:    reg_hit = 6'h08;
      ADDR_CMP0_SELECT:  reg_hit = 6'h10;
      ADDR_CMP1_SELECT:  reg_hit = 6'h20;
      default:           reg_hit = 6'h00;
    endcase
  endfunction : reg_hit

  // settle time after a configuration change, from the selected response time
  function automatic logic [4:0] settle_cycles(input logic [1:0] speed);
    case (speed)
      2'b00:   settle_cycles = MODE0_CYC;
      2'b01:   settle_cycles = MODE1_CYC;
      2'b10:   settle_cycles = MODE2_CYC;
      default: settle_cycles = MODE3_CYC;
    endcase
  endfunction : settle_cycles

  logic [5:0] wr_hit;
  logic [5:0] rd_hit;
  logic [7:0] next_rdata;

  // per-comparator register images for the read path
  logic [7:0] ctl_view  [2];
  logic [7:0] mode_view [2];
  logic [7:0] sel_view  [2];

  assign wr_hit = i_sfr_wr ? reg_hit(i_sfr_addr) : 6'h00;
  assign rd_hit = reg_hit(i_sfr_addr);

  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_cmp
      logic        on;
      logic [1:0]  pos_hyst;
      logic [1:0]  neg_hyst;
      logic        rise_irq_en;
      logic        fall_irq_en;
      logic [1:0]  speed_sel;
      logic [1:0]  pos_sel;
      logic [1:0]  neg_sel;
      logic        level;
      logic        rise_flag;
      logic        fall_flag;
      logic        ctl_wr;
      logic        mode_wr;
      logic        sel_wr;
      logic        retune;
      logic [1:0]  retune_speed;
      dccr_state_t state;
      dccr_state_t next_state;
      logic [4:0]  settle_cnt;
      logic [4:0]  next_settle_cnt;

      assign ctl_wr  = wr_hit[n];
      assign mode_wr = wr_hit[2 + n];
      assign sel_wr  = wr_hit[4 + n];
      // a new input pair or any mode write makes the comparator settle again
      assign retune  = sel_wr | mode_wr;
      // a mode write reloads with the speed being written, not the one it replaces
      assign retune_speed = mode_wr ? i_sfr_wdata[MOD_SPD_LSB +: 2] : speed_sel;

      // control register: enable and hysteresis; flags live in the edge block
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          on       <= RST_CONTROL[CTL_ON_BIT];
          pos_hyst <= RST_CONTROL[CTL_HYP_LSB +: 2];
          neg_hyst <= RST_CONTROL[CTL_HYN_LSB +: 2];
        end else if (ctl_wr) begin
          on       <= i_sfr_wdata[CTL_ON_BIT];
          pos_hyst <= i_sfr_wdata[CTL_HYP_LSB +: 2];
          neg_hyst <= i_sfr_wdata[CTL_HYN_LSB +: 2];
        end
      end

      // mode register: only the documented fields are stored
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          rise_irq_en <= RST_MODE[MOD_RIE_BIT];
          fall_irq_en <= RST_MODE[MOD_FIE_BIT];
          speed_sel   <= RST_MODE[MOD_SPD_LSB +: 2];
        end else if (mode_wr) begin
          rise_irq_en <= i_sfr_wdata[MOD_RIE_BIT];
          fall_irq_en <= i_sfr_wdata[MOD_FIE_BIT];
          speed_sel   <= i_sfr_wdata[MOD_SPD_LSB +: 2];
        end
      end

      // input select register; code 11 is stored as written, the part variant decides use
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          pos_sel <= RST_SELECT[SEL_POS_LSB +: 2];
          neg_sel <= RST_SELECT[SEL_NEG_LSB +: 2];
        end else if (sel_wr) begin
          pos_sel <= i_sfr_wdata[SEL_POS_LSB +: 2];
          neg_sel <= i_sfr_wdata[SEL_NEG_LSB +: 2];
        end
      end

      // settle sequencer: edges are only counted once the analog side has had its
      // response time, so that switching inputs does not raise a false flag
      always_comb begin
        next_state      = state;
        next_settle_cnt = settle_cnt;
        case (state)
          ST_OFF: begin
            if (on) begin
              next_state      = ST_SETTLE;
              next_settle_cnt = settle_cycles(retune_speed);
            end
          end
          ST_SETTLE: begin
            if (!on) begin
              next_state = ST_OFF;
            end else if (retune) begin
              next_settle_cnt = settle_cycles(retune_speed);
            end else if (settle_cnt <= 5'd1) begin
              next_state      = ST_ARMED;
              next_settle_cnt = 5'd0;
            end else begin
              next_settle_cnt = settle_cnt - 5'd1;
            end
          end
          ST_ARMED: begin
            if (!on) begin
              next_state = ST_OFF;
            end else if (retune) begin
              next_state      = ST_SETTLE;
              next_settle_cnt = settle_cycles(retune_speed);
            end
          end
          default: begin
            next_state      = ST_OFF;
            next_settle_cnt = 5'd0;
          end
        endcase
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          state      <= ST_OFF;
          settle_cnt <= 5'd0;
        end else begin
          state      <= next_state;
          settle_cnt <= next_settle_cnt;
        end
      end

      dccr_edge u_edge (
        .i_clk        (i_clk),
        .i_srst       (i_srst),
        .i_raw        (i_cmp_raw[n]),
        .i_arm        (state == ST_ARMED),
        .i_flag_wr    (ctl_wr),
        .i_rise_wdata (i_sfr_wdata[CTL_RISE_BIT]),
        .i_fall_wdata (i_sfr_wdata[CTL_FALL_BIT]),
        .o_level      (level),
        .o_rise_flag  (rise_flag),
        .o_fall_flag  (fall_flag)
      );

      dccr_route #(
        .POS_BASE (2 * n)
      ) u_route (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_pos_sel  (pos_sel),
        .i_neg_sel  (neg_sel),
        .o_pos_pins (o_cmp_pos_pins[n]),
        .o_neg_pins (o_cmp_neg_pins[n])
      );

      // request stays up while any enabled flag is set; software clears the flag to drop it
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_cmp_irq[n] <= 1'b0;
        end else begin
          o_cmp_irq[n] <= (rise_flag & rise_irq_en) | (fall_flag & fall_irq_en);
        end
      end

      // a disabled comparator must not leak its last level onto the pin
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_cmp_pin_out[n] <= 1'b0;
        end else begin
          o_cmp_pin_out[n] <= on & level;
        end
      end

      assign o_cmp_cfg[n] = '{on: on, pos_hyst: pos_hyst, neg_hyst: neg_hyst,
                              speed_sel: speed_sel};

      // register images as software reads them; unused bits are zero
      assign ctl_view[n] = {on, on & level, rise_flag, fall_flag,
                            pos_hyst, neg_hyst};
      assign mode_view[n] = {2'b00, rise_irq_en, fall_irq_en,
                             2'b00, speed_sel};
      assign sel_view[n] = {2'b00, neg_sel, 2'b00, pos_sel};
    end
  endgenerate

  // read mux; an unmapped address returns zero
  always_comb begin
    case (rd_hit)
      6'h01:   next_rdata = ctl_view[0];
      6'h02:   next_rdata = ctl_view[1];
      6'h04:   next_rdata = mode_view[0];
      6'h08:   next_rdata = mode_view[1];
      6'h10:   next_rdata = sel_view[0];
      6'h20:   next_rdata = sel_view[1];
      default: next_rdata = 8'h00;
    endcase
  end

  // read data holds until the next read strobe, so a slow core can sample it late
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= next_rdata;
    end
  end

endmodule : dccr_regs
`default_nettype wire

// [logic/dccr_pkg.sv]
/*
  dccr_pkg: register addresses, field positions, reset values, timing counts and carrier
  types of the dual comparator control register bank.
  Assumes a 25 MHz system clock and an 8-bit special-function register bus from the core.
*/
package dccr_pkg;

  // register addresses on the special-function register bus
  localparam logic [7:0] ADDR_CMP1_CONTROL = 8'h9A;
  localparam logic [7:0] ADDR_CMP0_CONTROL = 8'h9B;
  localparam logic [7:0] ADDR_CMP1_MODE    = 8'h9C;
  localparam logic [7:0] ADDR_CMP0_MODE    = 8'h9D;
  localparam logic [7:0] ADDR_CMP1_SELECT  = 8'h9E;
  localparam logic [7:0] ADDR_CMP0_SELECT  = 8'h9F;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h02;
  localparam logic [7:0] RST_SELECT  = 8'h00;

  // control register fields
  localparam int CTL_ON_BIT   = 7;
  localparam int CTL_RES_BIT  = 6;
  localparam int CTL_RISE_BIT = 5;
  localparam int CTL_FALL_BIT = 4;
  localparam int CTL_HYP_LSB  = 2;
  localparam int CTL_HYN_LSB  = 0;
  // mode register fields
  localparam int MOD_RIE_BIT  = 5;
  localparam int MOD_FIE_BIT  = 4;
  localparam int MOD_SPD_LSB  = 0;
  // input select register fields
  localparam int SEL_NEG_LSB  = 4;
  localparam int SEL_POS_LSB  = 0;

  // response times per speed mode, and the settle counts they give at the system clock
  localparam int CLK_MHZ    = 25;
  localparam int T_MODE0_NS = 100;
  localparam int T_MODE1_NS = 175;
  localparam int T_MODE2_NS = 320;
  localparam int T_MODE3_NS = 1050;
  localparam logic [4:0] MODE0_CYC = 5'((T_MODE0_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] MODE1_CYC = 5'((T_MODE1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] MODE2_CYC = 5'((T_MODE2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] MODE3_CYC = 5'((T_MODE3_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_SETTLE = 3'b010,
    ST_ARMED  = 3'b100
  } dccr_state_t;

  // settings handed to one analog comparator
  typedef struct packed {
    logic       on;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic [1:0] speed_sel;
  } dccr_cfg_t;

endpackage : dccr_pkg

// [logic/dccr_edge.sv]
/*
  dccr_edge: synchroniser, edge detector and sticky edge flags of one comparator.
  Assumes the raw comparator output is asynchronous; flag writes come from the register bank.
*/
`timescale 1ns/10ps
`default_nettype none
module dccr_edge (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_raw,
  input  wire logic i_arm,
  input  wire logic i_flag_wr,
  input  wire logic i_rise_wdata,
  input  wire logic i_fall_wdata,
  output logic      o_level,
  output logic      o_rise_flag,
  output logic      o_fall_flag
);
  import dccr_pkg::*;

  logic meta;
  logic prev;
  logic rise_evt;
  logic fall_evt;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta    <= 1'b0;
      o_level <= 1'b0;
      prev    <= 1'b0;
    end else begin
      meta    <= i_raw;
      o_level <= meta;
      prev    <= o_level;
    end
  end

  assign rise_evt = i_arm & o_level & ~prev;
  assign fall_evt = i_arm & ~o_level & prev;

  // a same-cycle edge beats a software clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rise_flag <= 1'b0;
      o_fall_flag <= 1'b0;
    end else begin
      o_rise_flag <= (i_flag_wr ? i_rise_wdata : o_rise_flag) | rise_evt;
      o_fall_flag <= (i_flag_wr ? i_fall_wdata : o_fall_flag) | fall_evt;
    end
  end

endmodule : dccr_edge
`default_nettype wire

// [logic/dccr_route.sv]
/*
  dccr_route: turns one comparator's input select codes into port pin connection masks.
  Assumes pins of port 1 in mask bits 7:0 and port 2 in bits 15:8; masks drive analog switches.
*/
`timescale 1ns/10ps
`default_nettype none
module dccr_route #(
  parameter int POS_BASE = 0
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic [1:0]  i_pos_sel,
  input  wire logic [1:0]  i_neg_sel,
  output logic      [15:0] o_pos_pins,
  output logic      [15:0] o_neg_pins
);
  import dccr_pkg::*;

  // code bit 0 steps the pin by four, code bit 1 moves from port 1 to port 2
  function automatic logic [15:0] pin_mask(input logic [1:0] code, input int base);
    logic [3:0] idx;
    idx = 4'(base + (code[0] ? 4 : 0) + (code[1] ? 8 : 0));
    pin_mask = 16'h0001 << idx;
  endfunction : pin_mask

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pos_pins <= pin_mask(2'b00, POS_BASE);
      o_neg_pins <= pin_mask(2'b00, POS_BASE + 1);
    end else begin
      o_pos_pins <= pin_mask(i_pos_sel, POS_BASE);
      o_neg_pins <= pin_mask(i_neg_sel, POS_BASE + 1);
    end
  end

endmodule : dccr_route
`default_nettype wire

// [bench/dccr_regs_sva.sv]
/*
  dccr_regs_sva: port-level checks of the comparator register bank.
  Assumes it is bound to dccr_regs and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module dccr_regs_sva (
  input  wire logic                     i_clk,
  input  wire logic                     i_srst,
  input  wire logic [7:0]               i_sfr_addr,
  input  wire logic                     i_sfr_wr,
  input  wire logic [7:0]               i_sfr_wdata,
  input  wire logic                     i_sfr_rd,
  input  wire logic [7:0]               o_sfr_rdata,
  input  wire logic [1:0]               i_cmp_raw,
  input  wire dccr_pkg::dccr_cfg_t [1:0] o_cmp_cfg,
  input  wire logic [1:0][15:0]         o_cmp_pos_pins,
  input  wire logic [1:0][15:0]         o_cmp_neg_pins,
  input  wire logic [1:0]               o_cmp_pin_out,
  input  wire logic [1:0]               o_cmp_irq
);
  import dccr_pkg::*;
  // write data one and two cycles back, to compare against delayed effects
  logic [7:0] wd_q;
  logic [7:0] wd_q2;
  always_ff @(posedge i_clk) begin
    wd_q <= i_sfr_wdata;
  end
  always_ff @(posedge i_clk) begin
    wd_q2 <= wd_q;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  a_ctl0_on:
  assert property (i_sfr_wr && i_sfr_addr == ADDR_CMP0_CONTROL |=> o_cmp_cfg[0].on == wd_q[7])
    else $error("comparator0 enable does not follow write");
  a_ctl1_fields:
  assert property (i_sfr_wr && i_sfr_addr == ADDR_CMP1_CONTROL |=>
    {o_cmp_cfg[1].on, o_cmp_cfg[1].pos_hyst, o_cmp_cfg[1].neg_hyst} == {wd_q[7], wd_q[3:0]})
    else $error("comparator1 control fields do not follow write");
  a_mode0_speed:
  assert property (i_sfr_wr && i_sfr_addr == ADDR_CMP0_MODE |=>
    o_cmp_cfg[0].speed_sel == wd_q[1:0]) else $error("comparator0 speed not updated");
  a_off_pin_low:
  assert property (!o_cmp_cfg[0].on [*2] |-> !o_cmp_pin_out[0])
    else $error("disabled comparator0 drives its pin");
  a_unmapped_zero:
  assert property (i_sfr_rd && (i_sfr_addr < ADDR_CMP1_CONTROL || i_sfr_addr > ADDR_CMP0_SELECT)
    |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold:
  assert property (!i_sfr_rd |=> $stable(o_sfr_rdata)) else $error("read data moved");
  a_unused_zero:
  assert property (i_sfr_rd && (i_sfr_addr == ADDR_CMP0_MODE || i_sfr_addr == ADDR_CMP0_SELECT)
    |=> (o_sfr_rdata & 8'hCC) == 8'h00) else $error("unused bits read nonzero");
  a_route0_pins:
  assert property (i_sfr_wr && i_sfr_addr == ADDR_CMP0_SELECT |-> ##2
    o_cmp_pos_pins[0] == 16'h0001 << {wd_q2[1:0], 2'b00} &&
    o_cmp_neg_pins[0] == 16'h0002 << {wd_q2[5:4], 2'b00}) else $error("comparator0 routing");
  a_route1_pins:
  assert property (i_sfr_wr && i_sfr_addr == ADDR_CMP1_SELECT |-> ##2
    o_cmp_pos_pins[1] == 16'h0004 << {wd_q2[1:0], 2'b00} &&
    o_cmp_neg_pins[1] == 16'h0008 << {wd_q2[5:4], 2'b00}) else $error("comparator1 routing");
endmodule : dccr_regs_sva

bind dccr_regs dccr_regs_sva u_sva (
  .i_clk(i_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
  .i_cmp_raw(i_cmp_raw), .o_cmp_cfg(o_cmp_cfg), .o_cmp_pos_pins(o_cmp_pos_pins),
  .o_cmp_neg_pins(o_cmp_neg_pins), .o_cmp_pin_out(o_cmp_pin_out), .o_cmp_irq(o_cmp_irq)
);
`default_nettype wire

// [bench/dccr_regs_tb.sv]
/*
  dccr_regs_tb: self-checking bench for the comparator register bank.
  Assumes dccr_regs and its checker are compiled first; inputs change on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module dccr_regs_tb;
  import dccr_pkg::*;
  logic                 i_clk;
  logic                 i_srst;
  logic [7:0]           i_sfr_addr;
  logic                 i_sfr_wr;
  logic [7:0]           i_sfr_wdata;
  logic                 i_sfr_rd;
  logic [7:0]           o_sfr_rdata;
  logic [1:0]           i_cmp_raw;
  dccr_cfg_t [1:0]      o_cmp_cfg;
  logic [1:0][15:0]     o_cmp_pos_pins;
  logic [1:0][15:0]     o_cmp_neg_pins;
  logic [1:0]           o_cmp_pin_out;
  logic [1:0]           o_cmp_irq;
  logic [1:0]           v;
  int                   errors = 0;
  int                   checked = 0;
  // the bench models the larger package, where the highest port-2 pins exist
  localparam bit        LARGE_PKG = 1'b1;

  dccr_regs dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
    .i_cmp_raw(i_cmp_raw), .o_cmp_cfg(o_cmp_cfg), .o_cmp_pos_pins(o_cmp_pos_pins),
    .o_cmp_neg_pins(o_cmp_neg_pins), .o_cmp_pin_out(o_cmp_pin_out), .o_cmp_irq(o_cmp_irq)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  // strobes last one cycle, then one idle cycle so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    cyc(1);
    i_sfr_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    cyc(1);
    i_sfr_rd = 1'b0;
    `CHK(o_sfr_rdata, e)
    cyc(1);
  endtask : rd

  // span is generous: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    final_report();
  end

  initial begin
    i_srst = 1'b1;
    i_sfr_addr = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_wdata = 8'h00;
    i_sfr_rd = 1'b0;
    i_cmp_raw = 2'b00;
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'b0;
    cyc(2);
    `CHK(o_cmp_pos_pins, {16'h0004, 16'h0001})
    `CHK(o_cmp_neg_pins, {16'h0008, 16'h0002})
    `CHK(o_cmp_cfg, {7'h02, 7'h02})
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_CMP1_CONTROL + 8'(i),
         (i == 2 || i == 3) ? RST_MODE : ((i > 3) ? RST_SELECT : RST_CONTROL));
    end
    for (int i = 2; i < 6; i++) begin
      wr(ADDR_CMP1_CONTROL + 8'(i), 8'hFF);
      rd(ADDR_CMP1_CONTROL + 8'(i), 8'h33);
    end
    for (int c = 0; c < (LARGE_PKG ? 4 : 3); c++) begin
      v = 2'(c);
      wr(ADDR_CMP0_CONTROL, {4'h4, v, v});
      wr(ADDR_CMP1_CONTROL, {4'h4, v, v});
      wr(ADDR_CMP0_MODE, {6'h00, v});
      wr(ADDR_CMP1_MODE, {6'h00, v});
      wr(ADDR_CMP0_SELECT, {2'b00, v, 2'b00, v});
      wr(ADDR_CMP1_SELECT, {2'b00, v, 2'b00, v});
      rd(ADDR_CMP0_CONTROL, {4'h0, v, v});
      rd(ADDR_CMP1_CONTROL, {4'h0, v, v});
      `CHK(o_cmp_cfg, {1'b0, v, v, v, 1'b0, v, v, v})
      `CHK(o_cmp_pos_pins, {16'h0004 << {v, 2'b00}, 16'h0001 << {v, 2'b00}})
      `CHK(o_cmp_neg_pins, {16'h0008 << {v, 2'b00}, 16'h0002 << {v, 2'b00}})
    end
    rd(8'h00, 8'h00);
    rd(8'hA0, 8'h00);
    // comparator0 edges with both interrupt enables, fastest response mode
    wr(ADDR_CMP0_MODE, 8'h30);
    wr(ADDR_CMP0_CONTROL, 8'h80);
    cyc(8);
    i_cmp_raw[0] = 1'b1;
    cyc(6);
    rd(ADDR_CMP0_CONTROL, 8'hE0);
    `CHK(o_cmp_irq[0], 1'b1)
    `CHK(o_cmp_pin_out[0], 1'b1)
    i_cmp_raw[0] = 1'b0;
    cyc(6);
    rd(ADDR_CMP0_CONTROL, 8'hB0);
    wr(ADDR_CMP0_CONTROL, 8'h80);
    cyc(1);
    `CHK(o_cmp_irq[0], 1'b0)
    cyc(4);
    rd(ADDR_CMP0_CONTROL, 8'h80);
    // rising flag with its enable off, then the enable turns on late
    wr(ADDR_CMP0_MODE, 8'h10);
    cyc(5);
    i_cmp_raw[0] = 1'b1;
    cyc(6);
    rd(ADDR_CMP0_CONTROL, 8'hE0);
    `CHK(o_cmp_irq[0], 1'b0)
    wr(ADDR_CMP0_MODE, 8'h30);
    cyc(1);
    `CHK(o_cmp_irq[0], 1'b1)
    wr(ADDR_CMP0_CONTROL, 8'h80);
    wr(ADDR_CMP0_MODE, 8'h10);
    cyc(5);
    i_cmp_raw[0] = 1'b0;
    cyc(6);
    `CHK(o_cmp_irq[0], 1'b1)
    rd(ADDR_CMP0_CONTROL, 8'h90);
    // turning off clears flags by the write and blanks the pin
    wr(ADDR_CMP0_CONTROL, 8'h00);
    i_cmp_raw[0] = 1'b1;
    cyc(6);
    `CHK(o_cmp_pin_out[0], 1'b0)
    `CHK(o_cmp_irq[0], 1'b0)
    rd(ADDR_CMP0_CONTROL, 8'h00);
    // comparator1 sees a full pulse
    wr(ADDR_CMP1_MODE, 8'h30);
    wr(ADDR_CMP1_CONTROL, 8'h80);
    cyc(8);
    i_cmp_raw[1] = 1'b1;
    cyc(6);
    `CHK(o_cmp_pin_out[1], 1'b1)
    i_cmp_raw[1] = 1'b0;
    cyc(6);
    rd(ADDR_CMP1_CONTROL, 8'hB0);
    `CHK(o_cmp_irq[1], 1'b1)
    wr(ADDR_CMP1_CONTROL, 8'h00);
    cyc(2);
    `CHK(o_cmp_irq[1], 1'b0)
    final_report();
  end
endmodule : dccr_regs_tb
`default_nettype wire
